// ### hdl/ira_pkg.sv
// register map, field layout and reset values of the indirect register access front end
package ira_pkg;

    // ------------------------------------------------------------------
    // main map offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_SELECT   = 8'h4c;
    localparam logic [7:0] OFS_IND_CONTROL   = 8'hb0;
    localparam logic [7:0] OFS_IND_OFFSET    = 8'hb1;
    localparam logic [7:0] OFS_IND_DATA      = 8'hb2;
    localparam logic [7:0] OFS_IDENT_FIVE    = 8'hf4;
    localparam logic [7:0] OFS_IDENT_SIX     = 8'hf5;
    localparam logic [7:0] OFS_PORT0_ALIAS   = 8'hf8;
    localparam logic [7:0] OFS_PORT1_ALIAS   = 8'hf9;
    localparam logic [7:0] OFS_SPARE_A       = 8'hfa;
    localparam logic [7:0] OFS_SPARE_B       = 8'hfb;

    // ------------------------------------------------------------------
    // field positions and write masks
    // ------------------------------------------------------------------
    localparam int         CTL_SEL_LSB       = 2;
    localparam int         CTL_SEL_MSB       = 5;
    localparam int         CTL_AUTO_INC_BIT  = 1;
    localparam logic [7:0] CTL_WRITE_MASK    = 8'h3e;
    localparam logic [7:0] ALIAS_WRITE_MASK  = 8'hfe;
    localparam int         PSEL_RD_PORT_BIT  = 4;
    localparam logic [7:0] PSEL_WRITE_MASK   = 8'h13;
    localparam int         PG_ON_BIT         = 0;
    localparam int         PG_SOLID_BIT      = 7;
    localparam int         PG_BARS_LSB       = 4;
    localparam int         PG_SIZE_LSB       = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_IND_CONTROL   = 8'h00;
    localparam logic [7:0] RST_IND_OFFSET    = 8'h00;
    localparam logic [7:0] RST_ALIAS         = 8'h00;
    localparam logic [7:0] RST_PORT_SELECT   = 8'h01;
    localparam logic [7:0] RST_PG_CONTROL    = 8'h00;
    localparam logic [7:0] RST_PG_CONFIG     = 8'h33;

    // ------------------------------------------------------------------
    // indirect pages and their offset ranges
    // ------------------------------------------------------------------
    localparam logic [3:0] PAGE_DIGITAL0     = 4'h0;
    localparam logic [3:0] PAGE_CHAN0        = 4'h1;
    localparam logic [3:0] PAGE_CHAN1        = 4'h2;
    localparam logic [3:0] PAGE_SHARE        = 4'h5;
    localparam logic [3:0] PAGE_WRITE_ALL    = 4'h6;
    localparam logic [3:0] PAGE_CSI_TX       = 4'h7;
    localparam logic [7:0] P0_PGEN_FIRST     = 8'h01;
    localparam logic [7:0] P0_PGEN_LAST      = 8'h1f;
    localparam logic [7:0] P0_CSI_FIRST      = 8'h40;
    localparam logic [7:0] P0_CSI_LAST       = 8'h48;
    localparam logic [7:0] CHAN_LAST         = 8'h14;
    localparam logic [7:0] SHARE_LAST        = 8'h04;
    localparam logic [7:0] CSI_TX_LAST       = 8'h1d;
    localparam logic [7:0] IND_PG_CONTROL    = 8'h01;
    localparam logic [7:0] IND_PG_CONFIG     = 8'h02;

    // source of a read answer held in the first pipeline stage
    typedef enum logic [1:0] {
        IRA_SRC_HOLD = 2'b00,
        IRA_SRC_MEM  = 2'b01,
        IRA_SRC_EXT  = 2'b10
    } ira_src_e;

    // registered state of the top module, apart from the indirect storage array and its read register
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] ofs;
        logic [7:0] alias0;
        logic [7:0] alias1;
        logic [7:0] port_sel;
        logic [7:0] pg_ctl;
        logic [7:0] pg_cfg;
        logic       s1_valid;
        ira_src_e   s1_src;
        logic [7:0] s1_hold;
        logic       rd_valid;
        logic [7:0] rd_data;
        logic       ext_wr;
        logic       ext_rd;
        logic [7:0] ext_addr;
        logic [7:0] ext_wdata;
        logic [1:0] ext_mask;
    } ira_state_s;

endpackage : ira_pkg

// ### hdl/ira_ind_mem.sv
// storage for the indirect register pages, with a registered read port
`timescale 1ns/10ps
`default_nettype none

module ira_ind_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 9
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output var  logic [DATA_W-1:0] rd_data
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad_param
        $error("ira_ind_mem: unsupported width or depth");
    end

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array: contents are undefined until software writes them
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : ira_ind_mem

`default_nettype wire

// ### hdl/ira_top.sv
// register access front end: ident bytes, port aliases, indirect window, pattern setup
`timescale 1ns/10ps
`default_nettype none

module ira_top
    import ira_pkg::*;
#(
    parameter logic [6:0] MAIN_DEV_ADDR = 7'h30,
    parameter logic [7:0] IDENT_FIVE    = 8'ha5, // value is arbitrary
    parameter logic [7:0] IDENT_SIX     = 8'h5a, // value is arbitrary
    parameter int         MEM_ADDR_W    = 9
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    // one access per pulse from the target front end
    input  wire logic       REQ_VALID,
    input  wire logic       REQ_WRITE,
    input  wire logic [6:0] REQ_DEV_ADDR,
    input  wire logic [7:0] REQ_REG_ADDR,
    input  wire logic [7:0] REQ_WDATA,
    // outside map answer, valid while a read is forwarded
    input  wire logic [7:0] EXT_RDATA,
    // claim and read answer
    output logic            REQ_ACK,
    output logic            RD_VALID,
    output logic      [7:0] RD_DATA,
    // forwarded access to the rest of the map
    output logic            EXT_WR,
    output logic            EXT_RD,
    output logic      [7:0] EXT_ADDR,
    output logic      [7:0] EXT_WDATA,
    output logic      [1:0] EXT_PORT_MASK,
    // pattern generator setup levels
    output logic            TEST_PATTERN_ON,
    output logic            SOLID_COLOR_SELECT,
    output logic      [1:0] BAR_COUNT,
    output logic      [3:0] FIXED_BLOCK_SIZE
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // slot layout assumes three page and six offset bits
    if (MEM_ADDR_W != 9) begin : g_bad_mem
        $error("ira_top: indirect storage needs exactly 9 address bits");
    end
    // zero is the disabled-alias code
    if (MAIN_DEV_ADDR == 7'h00) begin : g_bad_addr
        $error("ira_top: main device address must not be zero");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    // registered state and its next value
    ira_state_s            st;
    ira_state_s            next_st;
    // decode results
    logic                  hit_main;
    logic                  hit_alias0;
    logic                  hit_alias1;
    logic                  take;
    logic [1:0]            port_mask;

    // window and storage
    logic [3:0]            blk;
    logic                  ind_valid;
    logic                  ind_in_flops;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic                  mem_we;
    logic [7:0]            mem_rdata;
    logic                  owned;
    logic [7:0]            direct_rdata;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    // zero alias disables the decoder, so address 0 can never be claimed
    assign hit_main   = (REQ_DEV_ADDR == MAIN_DEV_ADDR);
    // alias sits in bits 7:1; bit 0 is ignored
    assign hit_alias0 = (st.alias0[7:1] != 7'h00) && (REQ_DEV_ADDR == st.alias0[7:1]);
    assign hit_alias1 = (st.alias1[7:1] != 7'h00) && (REQ_DEV_ADDR == st.alias1[7:1]);

    // unmatched addresses are left for other targets on the bus
    assign REQ_ACK = REQ_VALID && (hit_main || hit_alias0 || hit_alias1);
    // the acking edge is the taking edge
    assign take    = REQ_ACK;

    // port steering: alias wins over port select unless the main address also matches, port 0 alias wins a tie
    always_comb begin
        if (!hit_main && hit_alias0) begin
            port_mask = 2'b01;
        end else if (!hit_main && hit_alias1) begin
            port_mask = 2'b10;
        end else if (REQ_WRITE) begin
            port_mask = st.port_sel[1:0];
        end else if (st.port_sel[PSEL_RD_PORT_BIT]) begin
            port_mask = 2'b10;
        end else begin
            port_mask = 2'b01;
        end
    end

    // addresses this block answers itself; all others go to the outside map
    always_comb begin
        case (REQ_REG_ADDR)
            OFS_PORT_SELECT,
            OFS_IND_CONTROL,
            OFS_IND_OFFSET,
            OFS_IND_DATA,
            OFS_IDENT_FIVE,
            OFS_IDENT_SIX,
            OFS_PORT0_ALIAS,
            OFS_PORT1_ALIAS,
            OFS_SPARE_A,
            OFS_SPARE_B: owned = 1'b1;
            default:     owned = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // indirect window decode
    // ------------------------------------------------------------------
    // block code straight from the control flops
    assign blk = st.ctl[CTL_SEL_MSB:CTL_SEL_LSB];

    // only documented ranges of documented blocks are backed by storage
    always_comb begin
        case (blk)
            PAGE_DIGITAL0: begin
                ind_valid = ((st.ofs >= P0_PGEN_FIRST) && (st.ofs <= P0_PGEN_LAST))
                         || ((st.ofs >= P0_CSI_FIRST) && (st.ofs <= P0_CSI_LAST));
            end
            // debug pages are plain storage
            PAGE_CHAN0,
            PAGE_CHAN1,
            PAGE_WRITE_ALL: ind_valid = (st.ofs <= CHAN_LAST);
            PAGE_SHARE:     ind_valid = (st.ofs <= SHARE_LAST);
            PAGE_CSI_TX:    ind_valid = (st.ofs <= CSI_TX_LAST);
            default:        ind_valid = 1'b0;
        endcase
    end

    // pattern control and config sit in flops because they steer outputs
    assign ind_in_flops = (blk == PAGE_DIGITAL0)
                       && ((st.ofs == IND_PG_CONTROL) || (st.ofs == IND_PG_CONFIG));

    // page 0 CSI block folds into the upper half of its 64-entry slot
    assign mem_addr = st.ofs[6] ? {blk[2:0], 1'b1, st.ofs[4:0]}
                                : {blk[2:0], st.ofs[5:0]};

    // data-register write that lands in the storage array
    assign mem_we = take && REQ_WRITE && (REQ_REG_ADDR == OFS_IND_DATA)
                 && ind_valid && !ind_in_flops;

    // ------------------------------------------------------------------
    // indirect storage
    // ------------------------------------------------------------------
    // read and write share the current offset
    ira_ind_mem #(
        .DATA_W (8),
        .ADDR_W (MEM_ADDR_W)
    ) u_mem (
        .clk     (SYS_CLK),
        .wr_en   (mem_we),
        .wr_addr (mem_addr),
        .wr_data (REQ_WDATA),
        .rd_addr (mem_addr),
        .rd_data (mem_rdata)
    );

    // ------------------------------------------------------------------
    // direct read values of owned locations
    // ------------------------------------------------------------------
    // value of each owned location
    always_comb begin
        case (REQ_REG_ADDR)
            OFS_PORT_SELECT: direct_rdata = st.port_sel;
            OFS_IND_CONTROL: direct_rdata = st.ctl;
            OFS_IND_OFFSET:  direct_rdata = st.ofs;
            OFS_IDENT_FIVE:  direct_rdata = IDENT_FIVE;
            OFS_IDENT_SIX:   direct_rdata = IDENT_SIX;
            OFS_PORT0_ALIAS: direct_rdata = st.alias0 & ALIAS_WRITE_MASK;
            OFS_PORT1_ALIAS: direct_rdata = st.alias1 & ALIAS_WRITE_MASK;
            // refused offsets read zero
            OFS_IND_DATA: begin
                if (!ind_valid) begin
                    direct_rdata = 8'h00;
                end else if (st.ofs == IND_PG_CONTROL) begin
                    direct_rdata = st.pg_ctl;
                end else begin
                    direct_rdata = st.pg_cfg;
                end
            end
            default:         direct_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    // pulses drop every cycle; a request refills them
    always_comb begin
        next_st          = st;
        next_st.s1_valid = 1'b0;
        next_st.rd_valid = 1'b0;
        next_st.ext_wr   = 1'b0;
        next_st.ext_rd   = 1'b0;

        // second read stage picks the answer source and registers it
        if (st.s1_valid) begin
            next_st.rd_valid = 1'b1;
            case (st.s1_src)
                IRA_SRC_MEM:  next_st.rd_data = mem_rdata;
                IRA_SRC_EXT:  next_st.rd_data = EXT_RDATA;
                IRA_SRC_HOLD: next_st.rd_data = st.s1_hold;
                default:      next_st.rd_data = 8'h00;
            endcase
        end

        if (take && !owned) begin
            // everything else of the main map, port-specific or shared
            next_st.ext_addr  = REQ_REG_ADDR;
            next_st.ext_wdata = REQ_WDATA;
            next_st.ext_mask  = port_mask;
            next_st.ext_wr    = REQ_WRITE;
            next_st.ext_rd    = !REQ_WRITE;
            // answer returns through the outside port
            if (!REQ_WRITE) begin
                next_st.s1_valid = 1'b1;
                next_st.s1_src   = IRA_SRC_EXT;
            end
        end else if (take && REQ_WRITE) begin
            // owned write: only writable fields change
            case (REQ_REG_ADDR)
                OFS_PORT_SELECT: next_st.port_sel = REQ_WDATA & PSEL_WRITE_MASK;
                OFS_IND_CONTROL: next_st.ctl = REQ_WDATA & CTL_WRITE_MASK;
                OFS_IND_OFFSET:  next_st.ofs = REQ_WDATA;
                OFS_PORT0_ALIAS: next_st.alias0 = REQ_WDATA & ALIAS_WRITE_MASK;
                OFS_PORT1_ALIAS: next_st.alias1 = REQ_WDATA & ALIAS_WRITE_MASK;
                OFS_IND_DATA: begin
                    // pattern setup in flops, the rest in the array
                    if (ind_valid && (blk == PAGE_DIGITAL0) && (st.ofs == IND_PG_CONTROL)) begin
                        next_st.pg_ctl = REQ_WDATA;
                    end else if (ind_valid && (blk == PAGE_DIGITAL0)
                                 && (st.ofs == IND_PG_CONFIG)) begin
                        next_st.pg_cfg = REQ_WDATA;
                    end
                    // offset moves even when refused
                    if (st.ctl[CTL_AUTO_INC_BIT]) begin
                        next_st.ofs = st.ofs + 8'h01;
                    end
                end
                // ident and spare locations are read-only
                default: next_st.ctl = st.ctl;
            endcase
        end else if (take) begin
            // owned read: storage reads wait for the registered array output
            next_st.s1_valid = 1'b1;
            next_st.s1_hold  = direct_rdata;
            if ((REQ_REG_ADDR == OFS_IND_DATA) && ind_valid && !ind_in_flops) begin
                next_st.s1_src = IRA_SRC_MEM;
            end else begin
                next_st.s1_src = IRA_SRC_HOLD;
            end
            // array already latched the old offset
            if ((REQ_REG_ADDR == OFS_IND_DATA) && st.ctl[CTL_AUTO_INC_BIT]) begin
                next_st.ofs = st.ofs + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // synchronous reset; array contents are not cleared to save area
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            // fields not named below clear with the word
            st           <= '0;
            st.ctl       <= RST_IND_CONTROL;
            st.ofs       <= RST_IND_OFFSET;
            st.alias0    <= RST_ALIAS;
            st.alias1    <= RST_ALIAS;
            st.port_sel  <= RST_PORT_SELECT;
            st.pg_ctl    <= RST_PG_CONTROL;
            st.pg_cfg    <= RST_PG_CONFIG;
            st.s1_src    <= IRA_SRC_HOLD;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // pulses and forwarded fields from flops
    assign RD_VALID           = st.rd_valid;
    assign RD_DATA            = st.rd_data;
    assign EXT_WR             = st.ext_wr;
    assign EXT_RD             = st.ext_rd;
    assign EXT_ADDR           = st.ext_addr;
    assign EXT_WDATA          = st.ext_wdata;
    assign EXT_PORT_MASK      = st.ext_mask;

    // size 0 is passed as is; the generator must treat it as unsupported
    assign TEST_PATTERN_ON    = st.pg_ctl[PG_ON_BIT];
    assign SOLID_COLOR_SELECT = st.pg_cfg[PG_SOLID_BIT];
    assign BAR_COUNT          = st.pg_cfg[PG_BARS_LSB+1:PG_BARS_LSB];
    assign FIXED_BLOCK_SIZE   = st.pg_cfg[PG_SIZE_LSB+3:PG_SIZE_LSB];

endmodule : ira_top

`default_nettype wire

// ### tb/ira_checker.sv
// port checker for the register access front end
`timescale 1ns/10ps
`default_nettype none

module ira_checker #(
    parameter logic [6:0] MAIN_DEV_ADDR = 7'h30
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic       REQ_VALID,
    input  wire logic       REQ_WRITE,
    input  wire logic [6:0] REQ_DEV_ADDR,
    input  wire logic [7:0] REQ_REG_ADDR,
    input  wire logic [7:0] REQ_WDATA,
    input  wire logic       REQ_ACK,
    input  wire logic       RD_VALID,
    input  wire logic [7:0] RD_DATA,
    input  wire logic       EXT_WR,
    input  wire logic       EXT_RD,
    input  wire logic [7:0] EXT_WDATA,
    input  wire logic       TEST_PATTERN_ON
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // taken requests, split by direction
    wire logic tk_rd = REQ_VALID && REQ_ACK && !REQ_WRITE;
    wire logic tk_wr = REQ_VALID && REQ_ACK && REQ_WRITE;

    property p_ack_main;
        REQ_VALID && (REQ_DEV_ADDR == MAIN_DEV_ADDR) |-> REQ_ACK;
    endproperty
    a_ack_main: assert property (p_ack_main) else $error("main address not claimed");
    property p_ack_zero;
        REQ_VALID && (REQ_DEV_ADDR == 7'h00) |-> !REQ_ACK;
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("zero address claimed");
    property p_rd_lat;
        tk_rd |-> ##2 RD_VALID;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_cause;
        RD_VALID |-> $past(tk_rd, 2);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
    property p_spare_zero;
        tk_rd && (REQ_REG_ADDR inside {8'hfa, 8'hfb}) |-> ##2 RD_DATA == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare not zero");
    property p_fwd_wr;
        tk_wr && (REQ_REG_ADDR[7:4] == 4'h1) |=> EXT_WR && (EXT_WDATA == $past(REQ_WDATA));
    endproperty
    a_fwd_wr: assert property (p_fwd_wr) else $error("write not forwarded");
    property p_no_fwd;
        REQ_VALID && REQ_ACK && (REQ_REG_ADDR inside {8'hb0, 8'hb1, 8'hb2}) |=> !EXT_WR && !EXT_RD;
    endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("window access forwarded");
    property p_pg_hold;
        $changed(TEST_PATTERN_ON) |-> $past(tk_wr && (REQ_REG_ADDR == 8'hb2));
    endproperty
    a_pg_hold: assert property (p_pg_hold) else $error("enable moved by itself");
endmodule : ira_checker

bind ira_top ira_checker #(.MAIN_DEV_ADDR(MAIN_DEV_ADDR)) u_ira_checker (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_DEV_ADDR(REQ_DEV_ADDR), .REQ_REG_ADDR(REQ_REG_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_ACK(REQ_ACK), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .EXT_WR(EXT_WR),
    .EXT_RD(EXT_RD), .EXT_WDATA(EXT_WDATA), .TEST_PATTERN_ON(TEST_PATTERN_ON)
);
`default_nettype wire

// ### tb/ira_ext_map.sv
// model of the rest of the main map behind the forwarded access port
`timescale 1ns/10ps
`default_nettype none

module ira_ext_map (
    input  wire logic       clk,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;

    // store forwarded writes, remember the last answer
    always @(posedge clk) begin
        if (wr) mem[addr] <= wdata;
        if (rd) last <= mem[addr];
    end
    // outside a read the bus shows the inverted last answer, held until the next read
    assign rdata = rd ? mem[addr] : ~last;
endmodule : ira_ext_map
`default_nettype wire

// ### tb/tb_ira_top.sv
// self-checking bench for the register access front end
`timescale 1ns/10ps
`default_nettype none

module tb_ira_top;
    import ira_pkg::*;
    localparam logic [6:0] MAIN = 7'h30;
    localparam logic [7:0] ID5  = 8'h6c; // value is arbitrary
    localparam logic [7:0] ID6  = 8'hc9; // value is arbitrary
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       rv = 1'b0;
    logic       rw = 1'b0;
    logic [6:0] dev = 7'h00;
    logic [7:0] ra = 8'h00;
    logic [7:0] wd = 8'h00;
    logic       ack, rd_valid, ext_wr, ext_rd, pg_on, solid, ack_seen;
    logic [7:0] rd_data, ext_addr, ext_wdata, ext_rdata, got;
    logic [1:0] mask, bars;
    logic [3:0] bsize;
    int         err_count = 0;
    int         n_tests = 0;

    always #10 clk = ~clk;

    ira_top #(.MAIN_DEV_ADDR(MAIN), .IDENT_FIVE(ID5), .IDENT_SIX(ID6), .MEM_ADDR_W(9)) u_ira_top (
        .SYS_CLK(clk), .RST_N(rst_n), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_DEV_ADDR(dev),
        .REQ_REG_ADDR(ra), .REQ_WDATA(wd), .EXT_RDATA(ext_rdata), .REQ_ACK(ack),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .EXT_WR(ext_wr), .EXT_RD(ext_rd),
        .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata), .EXT_PORT_MASK(mask),
        .TEST_PATTERN_ON(pg_on), .SOLID_COLOR_SELECT(solid), .BAR_COUNT(bars),
        .FIXED_BLOCK_SIZE(bsize));
    ira_ext_map u_ira_ext_map (.clk(clk), .wr(ext_wr), .rd(ext_rd), .addr(ext_addr),
        .wdata(ext_wdata), .rdata(ext_rdata));

    // ------------------------------------------------------------
    // access and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] a);
        n_tests++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h got %h", nm, e, a);
        end
    endtask : chk

    // one-cycle request; a taken read is judged in the answer cycle
    task automatic xfer(input logic [6:0] d, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        rv = 1'b1;
        rw = w;
        dev = d;
        ra = a;
        wd = v;
        @(negedge clk);
        ack_seen = ack;
        @(posedge clk);
        #1;
        rv = 1'b0;
        if (!w && (ack_seen !== 1'b0)) begin
            @(posedge clk);
            #1;
            chk("rd_valid", 8'h01, 8'(rd_valid));
            got = rd_data;
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        xfer(MAIN, 1'b1, a, v);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        xfer(MAIN, 1'b0, a, 8'h00);
        chk(nm, e, got);
    endtask : rd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("pg_on", 8'h00, 8'(pg_on));
        chk("cfg", 8'h33, {solid, 1'b0, bars, bsize});
        rd("alias0", OFS_PORT0_ALIAS, 8'h00);
        rd("alias1", OFS_PORT1_ALIAS, 8'h00);
    endtask : t_reset

    // read-only bytes keep their value through a write
    task automatic t_fixed();
        logic [7:0] ofs [4] = '{8'hf4, 8'hf5, 8'hfa, 8'hfb};
        logic [7:0] exp [4] = '{ID5, ID6, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(ofs[i], 8'hff);
            rd("fixed", ofs[i], exp[i]);
        end
    endtask : t_fixed

    task automatic t_alias();
        xfer(7'h21, 1'b0, 8'h10, 8'h00);
        chk("ack_none", 8'h00, 8'(ack_seen));
        wr(OFS_PORT0_ALIAS, 8'h43);
        rd("alias0", OFS_PORT0_ALIAS, 8'h42);
        wr(OFS_PORT1_ALIAS, 8'h44);
        xfer(7'h21, 1'b1, 8'h10, 8'h77);
        chk("mask0", 8'h01, {6'h0, mask});
        xfer(7'h22, 1'b1, 8'h10, 8'h78);
        chk("mask1", 8'h02, {6'h0, mask});
        xfer(7'h22, 1'b0, OFS_PORT1_ALIAS, 8'h00);
        chk("shared", 8'h44, got);
        xfer(7'h22, 1'b0, 8'h10, 8'h00);
        chk("fwd_rd", 8'h78, got);
        wr(OFS_PORT0_ALIAS, 8'h00);
        xfer(7'h21, 1'b0, 8'h10, 8'h00);
        chk("ack_off", 8'h00, 8'(ack_seen));
        xfer(7'h00, 1'b0, 8'h10, 8'h00);
        chk("ack_zero", 8'h00, 8'(ack_seen));
    endtask : t_alias

    task automatic t_window();
        logic [7:0] pg [5] = '{8'h1c, 8'h1c, 8'h0c, 8'h04, 8'h14};
        logic [7:0] of [5] = '{8'h1d, 8'h1e, 8'h00, 8'h14, 8'h05};
        logic [7:0] ex [5] = '{8'h5a, 8'h00, 8'h00, 8'h5a, 8'h00};
        wr(OFS_IND_CONTROL, 8'hff);
        rd("ctl", OFS_IND_CONTROL, 8'h3e);
        wr(OFS_IND_CONTROL, 8'h02);
        wr(OFS_IND_OFFSET, IND_PG_CONTROL);
        wr(OFS_IND_DATA, 8'h01);
        chk("pg_on", 8'h01, 8'(pg_on));
        wr(OFS_IND_DATA, 8'h85);
        chk("cfg", 8'h85, {solid, 1'b0, bars, bsize});
        rd("ofs", OFS_IND_OFFSET, 8'h03);
        wr(OFS_IND_OFFSET, 8'h00);
        rd("rsvd", OFS_IND_DATA, 8'h00);
        rd("pg_ctl", OFS_IND_DATA, 8'h01);
        wr(OFS_IND_OFFSET, 8'h48);
        wr(OFS_IND_DATA, 8'h3c);
        wr(OFS_IND_OFFSET, 8'h48);
        rd("csi", OFS_IND_DATA, 8'h3c);
        // CSI TX page top, one past it, reserved page, channel and share pages
        for (int i = 0; i < 5; i++) begin
            wr(OFS_IND_CONTROL, pg[i]);
            wr(OFS_IND_OFFSET, of[i]);
            wr(OFS_IND_DATA, 8'h5a);
            wr(OFS_IND_OFFSET, of[i]);
            rd("page", OFS_IND_DATA, ex[i]);
        end
        wr(OFS_IND_CONTROL, 8'h00);
        wr(OFS_IND_OFFSET, IND_PG_CONFIG);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_IND_DATA, 8'(i * 16 + 3));
            chk("bars", 8'(i), {6'h0, bars});
        end
    endtask : t_window

    task automatic t_port();
        wr(8'h10, 8'h11);
        chk("psel_w0", 8'h01, {6'h0, mask});
        wr(OFS_PORT_SELECT, 8'h12);
        wr(8'h10, 8'h22);
        chk("psel_w1", 8'h02, {6'h0, mask});
        rd("psel_rd", 8'h10, 8'h22);
        chk("psel_r1", 8'h02, {6'h0, mask});
    endtask : t_port

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // watchdog: a stuck run counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_fixed();
        t_alias();
        t_window();
        t_port();
        close_out();
    end
endmodule : tb_ira_top
`default_nettype wire
